// >>> design/dcs_core.sv
// Digital core of a DDS clock synthesiser with Wishbone register access.
// Assumes the sample clock is i_core_clk; the analog dividers and driver take the config outputs.
`timescale 1ns/100ps

module dcs_core
   import dcs_pkg::*;
(
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rst_n,
   input  wire logic                  i_clk_en,
   input  wire logic                  i_master_reset,
   input  wire logic                  i_io_update,
   input  wire logic [2:0]            i_profile_select_inputs,
   input  wire logic                  i_wb_cyc,
   input  wire logic                  i_wb_stb,
   input  wire logic                  i_wb_we,
   input  wire logic [ADR_W-1:0]      i_wb_adr,
   input  wire logic [3:0]            i_wb_sel,
   input  wire logic [31:0]           i_wb_dat,
   output logic      [31:0]           o_wb_dat,
   output logic                       o_wb_ack,
   output logic      [DAC_W-1:0]      o_dac_word,
   output logic      [1:0]            o_rf_div_sel,
   output logic                       o_core_clk_undivided,
   output logic      [1:0]            o_cml_src,
   output logic      [3:0]            o_ref_div_m1,
   output logic      [3:0]            o_fb_div_m1,
   output logic                       o_xtal_osc_en,
   output logic      [2:0]            o_cp_scale_m1,
   output logic                       o_surge_rise_en,
   output logic                       o_surge_fall_en,
   output logic                       o_surge_default_off,
   output logic                       o_int_rset_en,
   output logic                       o_sync_clk
);

   // Buffered (software-written) and active register sets
   logic [31:0]      cfr1_buf_q, cfr1_q;
   logic [31:0]      second_control_function_register_buf_q, second_control_function_register_q;
   logic [15:0]      phs_buf_q, phs_q;
   logic [2:0]       psel_q;
   logic [ACC_W-1:0] ftw_buf_q [NPROF];
   logic [ACC_W-1:0] ftw_q     [NPROF];
   logic [DLY_W-1:0] dly_buf_q [NPROF];
   logic [DLY_W-1:0] dly_q     [NPROF];
   logic [2:0]       sel_s1_q, sel_s2_q;
   logic             upd_s1_q, upd_s2_q, mrst_s1_q, mrst_s2_q;
   logic [1:0]       sync_cnt_q;
   logic             sync_rise;
   logic [ACC_W-1:0] acc_q;
   logic [DLY_W-1:0] phase_q;
   logic             wr, rd_req;
   logic             hard_rst;

   // Profile select, update and master reset pins pass two flip-flops before use
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         sel_s1_q  <= 3'h0;
         sel_s2_q  <= 3'h0;
         upd_s1_q  <= 1'b0;
         upd_s2_q  <= 1'b0;
         mrst_s1_q <= 1'b0;
         mrst_s2_q <= 1'b0;
      end else if (i_clk_en) begin
         sel_s1_q  <= i_profile_select_inputs;
         sel_s2_q  <= sel_s1_q;
         upd_s1_q  <= i_io_update;
         upd_s2_q  <= upd_s1_q;
         mrst_s1_q <= i_master_reset;
         mrst_s2_q <= mrst_s1_q;
      end
   end

   assign hard_rst = !i_rst_n || mrst_s2_q;

   // Sync clock: sample clock divided by four, rising as the count reaches SYNC_DIV_LAST
   always_ff @(posedge i_core_clk) begin
      if (hard_rst) begin
         sync_cnt_q <= 2'h0;
         o_sync_clk <= 1'b0;
      end else if (i_clk_en) begin
         sync_cnt_q <= sync_cnt_q + 2'h1;
         o_sync_clk <= sync_cnt_q[1];
      end
   end
   assign sync_rise = (sync_cnt_q == SYNC_DIV_LAST);

   assign wr     = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
   assign rd_req = i_wb_cyc && i_wb_stb && !o_wb_ack;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
      end
      return r;
   endfunction

   // Wishbone slave: ack one cycle after the request, dropped the next
   always_ff @(posedge i_core_clk) begin
      if (hard_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0;
      end else if (i_clk_en) begin
         o_wb_ack <= rd_req;
         if (rd_req) begin
            unique case (i_wb_adr)
               ADR_CFR1:   o_wb_dat <= cfr1_buf_q;
               ADR_SECOND_CONTROL_FUNCTION_REGISTER:   o_wb_dat <= second_control_function_register_buf_q;
               ADR_STAT:   o_wb_dat <= {23'h0, psel_q, 2'h0, sync_cnt_q, 1'b0, sel_s2_q == psel_q};
               ADR_PSEL:   o_wb_dat <= {29'h0, psel_q};
               ADR_FTW_LO: o_wb_dat <= ftw_buf_q[psel_q][31:0];
               ADR_FTW_HI: o_wb_dat <= {16'h0, ftw_buf_q[psel_q][ACC_W-1:32]};
               ADR_DLY:    o_wb_dat <= {18'h0, dly_buf_q[psel_q]};
               ADR_PHS:    o_wb_dat <= {16'h0, phs_buf_q};
               default:    o_wb_dat <= 32'h0;
            endcase
         end
      end
   end

   // Software-side buffers; PSEL picks which profile the window addresses
   always_ff @(posedge i_core_clk) begin
      if (hard_rst) begin
         cfr1_buf_q <= CFR1_RST;
         second_control_function_register_buf_q <= SECOND_CONTROL_FUNCTION_REGISTER_RST;
         phs_buf_q  <= 16'h0;
         psel_q     <= 3'h0;
      end else if (i_clk_en && wr) begin
         if (i_wb_adr == ADR_CFR1) cfr1_buf_q <= merge(cfr1_buf_q, i_wb_dat, i_wb_sel);
         if (i_wb_adr == ADR_SECOND_CONTROL_FUNCTION_REGISTER) second_control_function_register_buf_q <= merge(second_control_function_register_buf_q, i_wb_dat, i_wb_sel);
         if (i_wb_adr == ADR_PHS) phs_buf_q <= 16'(merge({16'h0, phs_buf_q}, i_wb_dat, i_wb_sel));
         if (i_wb_adr == ADR_PSEL && i_wb_sel[0]) psel_q <= i_wb_dat[2:0];
      end
   end

   // Per-profile buffers and active copies
   for (genvar p = 0; p < NPROF; p++) begin : g_prof
      logic [63:0] fw;
      logic [31:0] dw;
      always_comb begin
         fw = {16'h0, ftw_buf_q[p]};
         dw = merge({18'h0, dly_buf_q[p]}, i_wb_dat, i_wb_sel);
         if (i_wb_adr == ADR_FTW_LO) fw[31:0]  = merge(fw[31:0], i_wb_dat, i_wb_sel);
         if (i_wb_adr == ADR_FTW_HI) fw[63:32] = merge(fw[63:32], i_wb_dat, i_wb_sel);
      end
      always_ff @(posedge i_core_clk) begin
         if (hard_rst) begin
            ftw_buf_q[p] <= '0;
            dly_buf_q[p] <= '0;
         end else if (i_clk_en && wr && psel_q == 3'(p)) begin
            if (i_wb_adr == ADR_FTW_LO || i_wb_adr == ADR_FTW_HI) ftw_buf_q[p] <= fw[ACC_W-1:0];
            if (i_wb_adr == ADR_DLY) dly_buf_q[p] <= dw[DLY_W-1:0];
         end
      end
      always_ff @(posedge i_core_clk) begin
         if (hard_rst) begin
            ftw_q[p] <= '0;
            dly_q[p] <= '0;
         end else if (i_clk_en && upd_s2_q && sync_rise) begin
            ftw_q[p] <= ftw_buf_q[p];
            dly_q[p] <= dly_buf_q[p];
         end
      end
   end

   // Active control registers
   always_ff @(posedge i_core_clk) begin
      if (hard_rst) begin
         cfr1_q <= CFR1_RST;
         second_control_function_register_q <= SECOND_CONTROL_FUNCTION_REGISTER_RST;
         phs_q  <= 16'h0;
      end else if (i_clk_en && upd_s2_q && sync_rise) begin
         cfr1_q <= cfr1_buf_q;
         second_control_function_register_q <= second_control_function_register_buf_q;
         phs_q  <= phs_buf_q;
      end
   end

   // Phase accumulator; wraps naturally at 2^48 (software keeps word <= 2^47)
   always_ff @(posedge i_core_clk) begin
      if (hard_rst) begin
         acc_q <= '0;
      end else if (i_clk_en) begin
         acc_q <= acc_q + ftw_q[sel_s2_q];
      end
   end

   // Offset: profile delay word plus global phase word, on the top 14 phase bits
   always_ff @(posedge i_core_clk) begin
      if (hard_rst) begin
         phase_q <= '0;
      end else if (i_clk_en) begin
         phase_q <= acc_q[ACC_W-1 -: DLY_W] + dly_q[sel_s2_q] + phs_q[DLY_W-1:0];
      end
   end

   // Cosine by quarter-wave symmetry with a parabolic approximation per quadrant
   logic [11:0] qx;
   logic [23:0] sq;
   logic [DAC_W-1:0] mag;
   always_comb begin
      qx  = phase_q[12] ? ~phase_q[11:0] : phase_q[11:0];
      sq  = qx * qx;
      mag = 10'(sq[23:15]);
   end

   always_ff @(posedge i_core_clk) begin
      if (hard_rst) begin
         o_dac_word <= 10'h200;
      end else if (i_clk_en) begin
         // Offset binary: top two phase bits give the cosine sign
         // Near a half turn qx is the distance to it, so the curve rises from the floor
         if (phase_q[13] ^ phase_q[12])
            o_dac_word <= 10'h001 + 10'(mag);
         else
            o_dac_word <= 10'h3fe - 10'(mag);
      end
   end

   // Configuration outputs from the active registers
   always_ff @(posedge i_core_clk) begin
      if (hard_rst) begin
         o_rf_div_sel         <= 2'h0;
         o_core_clk_undivided <= 1'b0;
         o_cml_src            <= 2'h0;
         o_ref_div_m1         <= 4'h0;
         o_fb_div_m1          <= 4'h0;
         o_xtal_osc_en        <= 1'b0;
         o_cp_scale_m1        <= 3'h0;
         o_surge_rise_en      <= 1'b0;
         o_surge_fall_en      <= 1'b0;
         o_surge_default_off  <= 1'b0;
         o_int_rset_en        <= 1'b0;
      end else if (i_clk_en) begin
         o_rf_div_sel         <= cfr1_q[F_RDIV +: 2];
         o_core_clk_undivided <= cfr1_q[F_SWAP];
         // Code 3 is not a source; it falls back to the feedback input
         o_cml_src            <= (cfr1_q[F_CMLSRC +: 2] > CML_FB) ? CML_FB
                                 : cfr1_q[F_CMLSRC +: 2];
         o_ref_div_m1         <= cfr1_q[F_MDIV +: 4];
         o_fb_div_m1          <= cfr1_q[F_NDIV +: 4];
         o_xtal_osc_en        <= cfr1_q[F_XTAL];
         o_cp_scale_m1        <= second_control_function_register_q[F_CPSCALE +: 3];
         o_surge_rise_en      <= second_control_function_register_q[F_SURGE_R];
         o_surge_fall_en      <= second_control_function_register_q[F_SURGE_F];
         o_surge_default_off  <= second_control_function_register_q[F_SURGE_OFF];
         o_int_rset_en        <= second_control_function_register_q[F_INT_RSET];
      end
   end

endmodule

// >>> include/dcs_pkg.sv
// Package for the clock synthesiser digital core: register map, fields, reset values.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package dcs_pkg;
   localparam int unsigned ACC_W       = 48;
   localparam int unsigned DAC_W       = 10;
   localparam int unsigned DLY_W       = 14;
   localparam int unsigned NPROF       = 8;
   localparam int unsigned ADR_W       = 8;
   // Register byte offsets
   localparam logic [7:0] ADR_CFR1     = 8'h00;
   localparam logic [7:0] ADR_SECOND_CONTROL_FUNCTION_REGISTER     = 8'h04;
   localparam logic [7:0] ADR_STAT     = 8'h08;
   localparam logic [7:0] ADR_PSEL     = 8'h0c;
   localparam logic [7:0] ADR_FTW_LO   = 8'h10;
   localparam logic [7:0] ADR_FTW_HI   = 8'h14;
   localparam logic [7:0] ADR_DLY      = 8'h18;
   localparam logic [7:0] ADR_PHS      = 8'h1c;
   // First control register fields
   localparam int unsigned F_RDIV      = 0;   // 2 bits: 0 -> /1, 1 -> /2, 2 -> /4, 3 -> /8
   localparam int unsigned F_SWAP      = 2;   // Divided clock to driver, undivided to core
   localparam int unsigned F_CMLSRC    = 3;   // 2 bits: 0 rf, 1 rf divided, 2 feedback
   localparam int unsigned F_MDIV      = 8;   // 4 bits: ratio minus one
   localparam int unsigned F_NDIV      = 12;  // 4 bits: ratio minus one
   localparam int unsigned F_XTAL      = 16;
   // Second control function register fields
   localparam int unsigned F_CPSCALE   = 0;   // 3 bits: multiplier minus one
   localparam int unsigned F_SURGE_R   = 3;
   localparam int unsigned F_SURGE_F   = 4;
   localparam int unsigned F_SURGE_OFF = 5;
   localparam int unsigned F_INT_RSET  = 6;
   localparam logic [31:0] CFR1_RST    = 32'h0000_0000;
   localparam logic [31:0] SECOND_CONTROL_FUNCTION_REGISTER_RST    = 32'h0000_0000;
   localparam logic [1:0]  SYNC_DIV_LAST = 2'h3;
   localparam logic [1:0]  CML_FB      = 2'h2;
endpackage

// >>> verif/dcs_core_chk.sv
// Checker for the synthesiser core: bus handshake, sync clock, resets, update gating.
// Assumes it is bound to dcs_core and sees only that module's ports.
`timescale 1ns/100ps
module dcs_core_chk
   import dcs_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_clk_en,
   input  wire logic              i_master_reset,
   input  wire logic              i_io_update,
   input  wire logic              i_wb_cyc,
   input  wire logic              i_wb_stb,
   input  wire logic              i_wb_we,
   input  wire logic [ADR_W-1:0]  i_wb_adr,
   input  wire logic [31:0]       o_wb_dat,
   input  wire logic              o_wb_ack,
   input  wire logic [DAC_W-1:0]  o_dac_word,
   input  wire logic [1:0]        o_rf_div_sel,
   input  wire logic              o_core_clk_undivided,
   input  wire logic [1:0]        o_cml_src,
   input  wire logic [2:0]        o_cp_scale_m1,
   input  wire logic              o_sync_clk
);
   // Cycles since the update strobe or master reset was last seen high, saturating
   logic [3:0] since_upd_q;
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n || i_master_reset || i_io_update) begin
         since_upd_q <= 4'h0;
      end else if (since_upd_q != 4'hf) begin
         since_upd_q <= since_upd_q + 4'h1;
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   a_ack_follows_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && i_clk_en
      |=> o_wb_ack) else $error("no ack after request");
   a_ack_one_cycle: assert property (o_wb_ack && i_clk_en |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");
   a_unmapped_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr >= 8'h20
      |-> o_wb_dat == 32'h0) else $error("unmapped read not zero");
   a_sync_period: assert property (@(posedge i_core_clk)
      disable iff (!i_rst_n || !i_clk_en || i_master_reset)
      $rose(o_sync_clk) |=> !$rose(o_sync_clk) [*3] ##1 $rose(o_sync_clk))
      else $error("sync clock period not four");
   a_master_clear: assert property ((i_master_reset && i_clk_en) [*5]
      |=> o_dac_word == 10'h200 && o_rf_div_sel == 2'h0 && o_cp_scale_m1 == 3'h0)
      else $error("master reset did not clear");
   a_cfg_after_update: assert property ($changed({o_rf_div_sel, o_core_clk_undivided,
      o_cml_src, o_cp_scale_m1}) |-> since_upd_q < 4'hc)
      else $error("config changed without update");
   a_enable_freeze: assert property (!i_clk_en
      |=> $stable(o_dac_word) && $stable(o_sync_clk) && $stable(o_wb_ack))
      else $error("state moved with enable low");
endmodule
bind dcs_core dcs_core_chk dcs_core_chk_inst (.*);

// >>> verif/dcs_dac_model.sv
// Converter-side model: takes one amplitude word per enabled sample clock.
// Assumes the word is registered on the same clock; keeps the last five words.
`timescale 1ns/100ps
module dcs_dac_model
   import dcs_pkg::*;
(
   input  wire logic                   i_core_clk,
   input  wire logic                   i_clk_en,
   input  wire logic [DAC_W-1:0]       i_dac_word,
   output logic      [4:0][DAC_W-1:0]  o_hist
);
   // A held sample clock holds the history too, so period checks stay exact
   always_ff @(posedge i_core_clk) begin
      if (i_clk_en) begin
         o_hist <= {o_hist[3:0], i_dac_word};
      end
   end
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the synthesiser core: registers, phase path, profiles, resets.
// Assumes dcs_core and the converter model; stimulus moves at the rising clock edge.
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench
   import dcs_pkg::*;
;
   logic i_core_clk, i_rst_n, i_clk_en, i_master_reset, i_io_update, i_wb_cyc, i_wb_stb;
   logic i_wb_we, o_wb_ack, o_core_clk_undivided, o_xtal_osc_en, o_surge_rise_en;
   logic o_surge_fall_en, o_surge_default_off, o_int_rset_en, o_sync_clk;
   logic [2:0]             i_profile_select_inputs, o_cp_scale_m1;
   logic [7:0]             i_wb_adr;
   logic [3:0]             i_wb_sel, o_ref_div_m1, o_fb_div_m1;
   logic [31:0]            i_wb_dat, o_wb_dat, rd, c1, c2;
   logic [1:0]             o_rf_div_sel, o_cml_src;
   logic [DAC_W-1:0]       o_dac_word;
   logic [4:0][DAC_W-1:0]  h;
   int                     fails = 0, comparisons = 0, cyc_cnt = 0;
   dcs_core dcs_core_inst (.*);
   dcs_dac_model dcs_dac_model_inst (.i_core_clk(i_core_clk), .i_clk_en(i_clk_en),
      .i_dac_word(o_dac_word), .o_hist(h));
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         fails++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (fails == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge i_core_clk);
      {i_wb_cyc, i_wb_stb, i_wb_sel} <= 6'h3f;
      {i_wb_we, i_wb_adr, i_wb_dat} <= {we, adr, dat};
      do @(posedge i_core_clk); while (o_wb_ack !== 1'b1);
      rd = o_wb_dat;
      {i_wb_cyc, i_wb_stb} <= 2'b00;
   endtask
   task automatic upd();
      i_io_update <= 1'b1;
      repeat (12) @(posedge i_core_clk);
      i_io_update <= 1'b0;
      repeat (8) @(posedge i_core_clk);
   endtask
   task automatic set_ftw(input logic [2:0] p, input logic [47:0] f);
      wb(1'b1, ADR_PSEL, {29'h0, p});
      wb(1'b1, ADR_FTW_LO, f[31:0]);
      wb(1'b1, ADR_FTW_HI, {16'h0, f[47:32]});
   endtask
   task automatic t_phase();
      wb(1'b1, 8'h20, 32'hffff_ffff);
      wb(1'b0, 8'h20, 32'h0);
      `CHK(rd, 32'h0)
      wb(1'b0, ADR_SECOND_CONTROL_FUNCTION_REGISTER, 32'h0);
      `CHK(rd, SECOND_CONTROL_FUNCTION_REGISTER_RST)
      upd();
      `CHK(h[0] >= 10'h3f0, 1'b1)
      wb(1'b1, ADR_PHS, 32'h2000);
      upd();
      `CHK(h[0] <= 10'h00f, 1'b1)
      wb(1'b1, ADR_PHS, 32'h1000);
      upd();
      `CHK(h[0] - 10'h1f0 <= 10'h20, 1'b1)
      wb(1'b1, ADR_PHS, 32'h0);
      wb(1'b1, ADR_DLY, 32'h2000);
      `CHK(h[0] - 10'h1f0 <= 10'h20, 1'b1)
      upd();
      `CHK(h[0] <= 10'h00f, 1'b1)
      wb(1'b1, ADR_DLY, 32'h0);
   endtask
   task automatic t_ftw();
      // Half turn first, so the quarter-turn run starts on an aligned phase
      set_ftw(3'h0, 48'h8000_0000_0000);
      upd();
      `CHK(h[2], h[0])
      `CHK(h[1] == h[0], 1'b0)
      `CHK({1'b0, h[1]} + h[0] - 11'h3fd <= 11'h4, 1'b1)
      set_ftw(3'h0, 48'h4000_0000_0000);
      upd();
      `CHK(h[4], h[0])
      `CHK(h[2] == h[0], 1'b0)
      set_ftw(3'h5, 48'h8000_0000_0000);
      upd();
      i_profile_select_inputs <= 3'h5;
      repeat (12) @(posedge i_core_clk);
      `CHK(h[2], h[0])
      i_profile_select_inputs <= 3'h0;
      repeat (12) @(posedge i_core_clk);
      `CHK(h[2] == h[0], 1'b0)
   endtask
   task automatic t_cfg();
      // Divider ratios stay within what the clock inputs allow
      for (int k = 0; k < 4; k++) begin
         c1 = {15'h0, k[1], 4'hf - 4'(k * 5), 4'(k * 5), 3'h0, 2'(k % 3), k[0], 2'(k)};
         c2 = {25'h0, k[0], k[1], ~k[0], k[0] ^ k[1], 3'(7 - 2 * k)};
         wb(1'b1, ADR_CFR1, c1);
         wb(1'b1, ADR_SECOND_CONTROL_FUNCTION_REGISTER, c2);
         wb(1'b0, ADR_CFR1, 32'h0);
         `CHK(rd, c1)
         `CHK(o_rf_div_sel, 2'((k == 0) ? 0 : k - 1))
         upd();
         `CHK({o_xtal_osc_en, o_fb_div_m1, o_ref_div_m1, o_cml_src, o_core_clk_undivided,
            o_rf_div_sel}, {c1[16:8], c1[4:0]})
         `CHK({o_int_rset_en, o_surge_default_off, o_surge_fall_en, o_surge_rise_en,
            o_cp_scale_m1}, c2[6:0])
      end
   endtask
   task automatic t_reset();
      i_clk_en <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      {i_clk_en, i_master_reset} <= 2'b11;
      repeat (6) @(posedge i_core_clk);
      `CHK(o_dac_word, 10'h200)
      i_master_reset <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      wb(1'b0, ADR_CFR1, 32'h0);
      `CHK(rd, CFR1_RST)
      `CHK(o_rf_div_sel, 2'h0)
   endtask
   initial begin
      {i_rst_n, i_clk_en, i_master_reset, i_io_update} = 4'b0100;
      {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} = '0;
      i_profile_select_inputs = 3'h0;
      repeat (8) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      t_phase();
      t_ftw();
      t_cfg();
      t_reset();
      complete_run();
   end
endmodule
